/* tb/burner_status_remote_command_regs_test.sv */
// Self-checking bench for the burner status and remote command register slice.
// Assumes the register master model in reg_master.sv and a short refresh count.
`timescale 1ns/1ns

module burner_status_remote_command_regs_test;
  localparam int RC = 16;
  logic i_clock;
  logic i_rst_n;
  burner_regs_pkg::reg_req_t req;
  burner_regs_pkg::ctl_status_t ctl;
  logic rd_valid;
  logic [15:0] rd_data;
  burner_regs_pkg::mode_t mode;
  logic remote_reset;
  int fail_count = 0;
  int compares = 0;
  burner_regs_pkg::mode_t modes [3] = '{burner_regs_pkg::MODE_OFF, burner_regs_pkg::MODE_HIGH,
                                        burner_regs_pkg::MODE_LOW};

  burner_status_remote_command_regs #(.REFRESH_CYCLES(32'(RC))) u_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req), .i_ctl(ctl),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_mode(mode), .o_remote_reset(remote_reset));
  reg_master u_master (.i_clock(i_clock), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_req(req));

  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // ----------------------------------------
  // Compare and access helpers
  // ----------------------------------------
  task automatic check_word(input logic valid, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (valid !== 1'b1 || got !== exp) begin
      fail_count++;
      $display("Error at %0t: word %h valid %b, expected %h", $time, got, valid, exp);
    end
  endtask : check_word

  task automatic check_mode(input burner_regs_pkg::mode_t exp);
    compares++;
    if (mode !== exp) begin
      fail_count++;
      $display("Error at %0t: mode %b, expected %b", $time, mode, exp);
    end
  endtask : check_mode

  task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_master.read_word(addr, d, v);
    check_word(v, d, exp);
  endtask : rd

  task automatic wc(input logic [15:0] cmd);
    u_master.write_word(16'h007f, cmd);
  endtask : wc

  task automatic finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_status;
    ctl = '{16'h1234, 16'h0003, 16'h00a5, 16'h0258, 32'h3f00_0061};
    rd(16'h0066, 16'h1234);
    rd(16'h0068, 16'h00a5);
    rd(16'h0069, 16'h0258);
    rd(16'h006a, 16'h0061);
    rd(16'h006b, 16'h3f00);
    for (int c = 0; c < 6; c++) begin
      ctl.valve_proving_config = 16'(c);
      rd(16'h0067, (c <= 4) ? 16'(c) : 16'h0000);
    end
  endtask : test_status

  task automatic test_commands;
    for (int i = 0; i < 3; i++) begin
      wc({i[0], 7'h7f, 8'h01 << (i + 1)});
      check_mode(modes[i]);
      rd(16'h0054, {i[0], 15'h0000} | (16'h0001 << (i + 1)));
    end
    wc(16'h0030);
    check_mode(burner_regs_pkg::MODE_LOW);
    rd(16'h0054, 16'h0008);
    wc(16'h0001);
    check_mode(burner_regs_pkg::MODE_AUTO);
    wc(16'h8010);
    check_word(1'b1, {15'h0000, remote_reset}, 16'h0001);
    @(negedge i_clock);
    check_word(1'b1, {15'h0000, remote_reset}, 16'h0000);
    rd(16'h0054, 16'h8010);
    rd(16'h007f, 16'h8011);
  endtask : test_commands

  task automatic test_unused;
    wc(16'h0004);
    u_master.write_word(16'h0069, 16'h0001);
    u_master.write_word(16'h006c, 16'h0002);
    u_master.write_word(16'h007e, 16'h0008);
    check_mode(burner_regs_pkg::MODE_HIGH);
    rd(16'h0069, 16'h0258);
    rd(16'h006c, 16'h0000);
    rd(16'h007e, 16'h0000);
  endtask : test_unused

  task automatic test_lapse;
    wc(16'h0002);
    u_master.refresh(16'h0002, 8, 3);
    repeat (RC - 1) @(negedge i_clock);
    check_mode(burner_regs_pkg::MODE_OFF);
    @(negedge i_clock);
    check_mode(burner_regs_pkg::MODE_AUTO);
  endtask : test_lapse

  initial begin
    i_rst_n = 1'b0;
    ctl = '0;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    i_rst_n = 1'b1;
    test_status();
    test_commands();
    test_unused();
    test_lapse();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge i_clock);
    fail_count++;
    finish_test();
  end
endmodule : burner_status_remote_command_regs_test

/* tb/reg_master.sv */
// Register master model that issues reads and writes to the burner register slice.
// Assumes the bench calls its tasks; the request changes only at falling edges.
`timescale 1ns/1ns

module reg_master (
  input wire logic i_clock,
  input wire logic i_rd_valid,
  input wire logic [15:0] i_rd_data,
  output burner_regs_pkg::reg_req_t o_req
);
  initial begin
    o_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: 16'hffff, wdata: 16'hffff};
  end

  // One access per call; released address and data lines show the inverse of the last value, enables go low
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] wdata);
    @(negedge i_clock);
    o_req = '{wr_en: wr, rd_en: !wr, addr: addr, wdata: wdata};
    @(negedge i_clock);
    o_req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access

  // Command words carry one low-byte bit and zero bits 5-7 unless a bench scenario asks otherwise
  task automatic write_word(input logic [15:0] addr, input logic [15:0] wdata);
    access(1'b1, addr, wdata);
  endtask : write_word

  task automatic read_word(input logic [15:0] addr, output logic [15:0] data, output logic valid);
    access(1'b0, addr, 16'h0000);
    data = i_rd_data;
    valid = i_rd_valid;
  endtask : read_word

  // Rewrites a held command well inside the refresh interval
  task automatic refresh(input logic [15:0] cmd, input int gap, input int count);
    repeat (count) begin
      repeat (gap) @(negedge i_clock);
      write_word(16'h007f, cmd);
    end
  endtask : refresh
endmodule : reg_master

/* verilog/burner_regs_consts.svh */
// Offsets, field positions, reset values and timing for the burner register slice.
// Assumes a 25 MHz system clock and word-addressed register offsets.
`ifndef BURNER_REGS_CONSTS_SVH
`define BURNER_REGS_CONSTS_SVH

`define ADDR_CMD_STATUS 16'h0054
`define ADDR_POST_PURGE 16'h0066
`define ADDR_PROVING_CFG 16'h0067
`define ADDR_PROVING_OPT 16'h0068
`define ADDR_PROVING_SEC 16'h0069
`define ADDR_TERM_LO 16'h006a
`define ADDR_TERM_HI 16'h006b
`define ADDR_UNUSED_FIRST 16'h006c
`define ADDR_UNUSED_LAST 16'h007e
`define ADDR_REMOTE_CMD 16'h007f

`define CMD_BIT_AUTO 0
`define CMD_BIT_OFF 1
`define CMD_BIT_HIGH 2
`define CMD_BIT_LOW 3
`define CMD_BIT_RESET 4
`define CMD_BIT_ECHO 15

`define TERM_RUN_TEST 0
`define TERM_FAN 5
`define TERM_ALARM 24
`define TERM_MODULATE 25
`define TERM_RESET 26
`define TERM_SAFETY_RELAY 27
`define TERM_FLAME_INTERLOCK 28
`define TERM_SECOND_MAIN_VALVE 29

`define PROVING_MAX_CODE 16'h0004
`define RESET_WORD 16'h0000

`define CLOCK_HZ 25000000
`define REFRESH_TIME_S 120

`endif

/* verilog/burner_regs_pkg.sv */
// Types for the burner status and remote command register slice.
// Assumes the constants header is included by users that need numbers.
package burner_regs_pkg;

  typedef enum logic [3:0] {
    MODE_AUTO = 4'b0001,
    MODE_OFF = 4'b0010,
    MODE_HIGH = 4'b0100,
    MODE_LOW = 4'b1000
  } mode_t;

  typedef struct packed {
    logic [15:0] post_purge_seconds;
    logic [15:0] valve_proving_config;
    logic [15:0] proving_option_word;
    logic [15:0] valve_proving_seconds;
    logic [31:0] terminal_state_word;
  } ctl_status_t;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    mode_t mode;
    logic [31:0] refresh_count;
    logic echo;
    logic reset_sent;
    logic reset_pulse;
    logic rd_valid;
    logic [15:0] rd_data;
  } state_t;

endpackage : burner_regs_pkg

/* verilog/burner_status_remote_command_regs.sv */
// Register slice: burner controller status mirror and remote command word.
// Assumes a single clock, synchronous active-low reset, word-addressed access.
`timescale 1ns/1ns
`include "burner_regs_consts.svh"

module burner_status_remote_command_regs #(
  parameter logic [31:0] REFRESH_CYCLES = 32'(64'(`REFRESH_TIME_S) * 64'(`CLOCK_HZ))
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire burner_regs_pkg::reg_req_t i_req,
  input wire burner_regs_pkg::ctl_status_t i_ctl,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data,
  output burner_regs_pkg::mode_t o_mode,
  output logic o_remote_reset
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // A count below 2 leaves no cycle between load and lapse
  if (REFRESH_CYCLES < 32'd2) begin : g_bad_refresh
    $error("REFRESH_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic low_byte_one_hot(input logic [15:0] w);
    logic [7:0] b;
    b = w[7:0];
    return (b != 8'h00) && ((b & (b - 8'h01)) == 8'h00) && (b[7:5] == 3'h0);
  endfunction : low_byte_one_hot

  function automatic logic [15:0] proving_code(input logic [15:0] raw);
    return (raw > `PROVING_MAX_CODE) ? 16'h0000 : raw;
  endfunction : proving_code

  burner_regs_pkg::state_t s_q;
  burner_regs_pkg::state_t s_d;
  logic cmd_write;
  logic cmd_valid;
  logic reset_cmd;

  assign cmd_write = i_req.wr_en && (i_req.addr == `ADDR_REMOTE_CMD);
  assign cmd_valid = cmd_write && low_byte_one_hot(i_req.wdata);
  assign reset_cmd = cmd_valid && (i_req.wdata[7:0] == 8'h10);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.reset_pulse = 1'b0;
    s_d.rd_valid = i_req.rd_en;
    // Commanded states hold only while refreshed
    if (s_q.mode != burner_regs_pkg::MODE_AUTO) begin
      if (s_q.refresh_count == 32'h0000_0000) begin
        s_d.mode = burner_regs_pkg::MODE_AUTO;
      end else begin
        s_d.refresh_count = s_q.refresh_count - 32'h0000_0001;
      end
    end
    // Only the command offset is writable; everything else falls through
    if (cmd_write) begin
      s_d.echo = i_req.wdata[`CMD_BIT_ECHO];
    end
    if (cmd_valid) begin
      // Bits 15:8 other than the echo are never looked at
      case (i_req.wdata[7:0])
        8'h01: begin
          s_d.mode = burner_regs_pkg::MODE_AUTO;
          s_d.reset_sent = 1'b0;
        end
        8'h02: begin
          s_d.mode = burner_regs_pkg::MODE_OFF;
          s_d.refresh_count = REFRESH_CYCLES - 32'h0000_0001;
          s_d.reset_sent = 1'b0;
        end
        8'h04: begin
          s_d.mode = burner_regs_pkg::MODE_HIGH;
          s_d.refresh_count = REFRESH_CYCLES - 32'h0000_0001;
          s_d.reset_sent = 1'b0;
        end
        8'h08: begin
          s_d.mode = burner_regs_pkg::MODE_LOW;
          s_d.refresh_count = REFRESH_CYCLES - 32'h0000_0001;
          s_d.reset_sent = 1'b0;
        end
        8'h10: begin
          s_d.reset_pulse = 1'b1;
          s_d.reset_sent = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Read mux; unused and unmapped offsets read as zero
    s_d.rd_data = 16'h0000;
    if (i_req.rd_en) begin
      case (i_req.addr)
        `ADDR_CMD_STATUS: begin
          s_d.rd_data = {s_q.echo, 10'h000, s_q.reset_sent, s_q.mode[3:1], 1'b0};
        end
        `ADDR_POST_PURGE: begin
          s_d.rd_data = i_ctl.post_purge_seconds;
        end
        `ADDR_PROVING_CFG: begin
          s_d.rd_data = proving_code(i_ctl.valve_proving_config);
        end
        `ADDR_PROVING_OPT: begin
          s_d.rd_data = i_ctl.proving_option_word;
        end
        `ADDR_PROVING_SEC: begin
          s_d.rd_data = i_ctl.valve_proving_seconds;
        end
        `ADDR_TERM_LO: begin
          s_d.rd_data = i_ctl.terminal_state_word[15:0];
        end
        `ADDR_TERM_HI: begin
          s_d.rd_data = i_ctl.terminal_state_word[31:16];
        end
        `ADDR_REMOTE_CMD: begin
          s_d.rd_data = {s_q.echo, 10'h000, s_q.reset_sent, s_q.mode[3:1], s_q.mode[0]};
        end
        default: begin
          s_d.rd_data = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      s_q.mode <= burner_regs_pkg::MODE_AUTO;
      s_q.refresh_count <= 32'h0000_0000;
      s_q.echo <= 1'b0;
      s_q.reset_sent <= 1'b0;
      s_q.reset_pulse <= 1'b0;
      s_q.rd_valid <= 1'b0;
      s_q.rd_data <= `RESET_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rd_valid = s_q.rd_valid;
  assign o_rd_data = s_q.rd_data;
  assign o_mode = s_q.mode;
  assign o_remote_reset = s_q.reset_pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_proving_seconds: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_PROVING_SEC |=> o_rd_data == $past(i_ctl.valve_proving_seconds))
    else $error("proving seconds readback wrong");

  chk_proving_code: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_PROVING_CFG |=> o_rd_data <= 16'h0004)
    else $error("proving config out of range");

  chk_proving_passthru: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_PROVING_CFG && i_ctl.valve_proving_config <= 16'h0004
    |=> o_rd_data == $past(i_ctl.valve_proving_config))
    else $error("proving config code altered");

  chk_terminal_word: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_TERM_HI |=> o_rd_data == $past(i_ctl.terminal_state_word[31:16]))
    else $error("terminal high word wrong");

  chk_terminal_low: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_TERM_LO |=> o_rd_data == $past(i_ctl.terminal_state_word[15:0]))
    else $error("terminal low word wrong");

  chk_unused_zero: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr >= `ADDR_UNUSED_FIRST && i_req.addr <= `ADDR_UNUSED_LAST |=> o_rd_data == 16'h0000)
    else $error("unused offset not zero");

  chk_high_fire: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write && i_req.wdata[7:0] == 8'h04 |=> o_mode == burner_regs_pkg::MODE_HIGH)
    else $error("high fire not taken");

  chk_auto_clear: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write && i_req.wdata[7:0] == 8'h01 |=> o_mode == burner_regs_pkg::MODE_AUTO)
    else $error("autonomous command not taken");

  chk_bad_command: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write && !cmd_valid && s_q.refresh_count != 32'h0000_0000 |=> $stable(o_mode) && !o_remote_reset)
    else $error("malformed command had effect");

  // Back-to-back reset commands may keep the pulse high for a second cycle
  chk_reset_pulse: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_remote_reset |-> $past(reset_cmd) ##1 (o_remote_reset == $past(reset_cmd)))
    else $error("remote reset pulse wrong");

  chk_ignore_high: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write && i_req.wdata[7:0] == 8'h08 && i_req.wdata[14:8] != 7'h00 |=> o_mode == burner_regs_pkg::MODE_LOW)
    else $error("bits 8-14 not ignored");

  chk_echo_copy: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write |=> s_q.echo == $past(i_req.wdata[15]))
    else $error("echo bit not copied");

  chk_echo_readback: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.rd_en && i_req.addr == `ADDR_CMD_STATUS |=> o_rd_data[15] == $past(s_q.echo))
    else $error("echo bit not reported");

  chk_refresh_load: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    cmd_write && i_req.wdata[7:0] == 8'h02
    |=> o_mode == burner_regs_pkg::MODE_OFF && s_q.refresh_count == REFRESH_CYCLES - 32'h0000_0001)
    else $error("refresh count not loaded");

  chk_lapse_auto: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_mode != burner_regs_pkg::MODE_AUTO && s_q.refresh_count == 32'h0000_0000 && !cmd_write
    |=> o_mode == burner_regs_pkg::MODE_AUTO)
    else $error("commanded state outlived refresh");

  chk_ro_write: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_req.wr_en && i_req.addr != `ADDR_REMOTE_CMD && s_q.refresh_count != 32'h0000_0000
    |=> $stable(o_mode) && $stable(s_q.echo) && !o_remote_reset)
    else $error("write to read-only offset had effect");

endmodule : burner_status_remote_command_regs
